// file: hdl/dss_defines.vh
// Constants for the dual-slope phase sequencer host controller.
// Assumes a 250 MHz system clock; included by bare name.
// Operation
// - Host drives both select pins from registers, steady through each phase.
// - Host treats comparator falling edge in deintegrate as conversion complete.
// - Host samples comparator at end of integrate and keeps it as sign.
// - Host ignores comparator level during auto-zero.
// - Integrator-clear phase length is set by the comparator, not fixed.
// - Integrate time is a whole multiple of the line period, e.g. 66 ms.
// - Deintegrate begins immediately when the integrate period expires.
// - Host ends deintegrate as soon as the zero crossing is seen.
// - Deintegrate count limit is twice the integrate count length.
// - Host reacts to the deintegrate falling edge with minimal latency.
// - Host ends integrator clear as soon as the comparator returns high.
// - Comparator is observed on an input and timed against host timer.
// - Comparator level is also read as a plain input for sign and clear.
// - Codes: integrate A=1,B=0; deintegrate A=1,B=1; timer runs to falling edge.
// - Codes: clear A=0,B=0; auto-zero A=0,B=1; auto-zero follows clear.
// - Each conversion runs auto-zero, integrate, deintegrate, clear in order.
// - Auto-zero is the idle state between conversions.
`ifndef DSS_DEFINES_VH
`define DSS_DEFINES_VH

`define DSS_CLK_MHZ        250
`define DSS_TINT_MS        66
`define DSS_TINT_CYCLES    (`DSS_TINT_MS * 1000 * `DSS_CLK_MHZ)
`define DSS_CMP_DELAY_US   2
`define DSS_CMP_DELAY_CYC  (`DSS_CMP_DELAY_US * `DSS_CLK_MHZ)
`define DSS_TICK_DIV       250
`define DSS_CNT_W          32
`define DSS_DIV_W          16
`define DSS_AB_INTEGRATE   2'h2
`define DSS_AB_DEINTEGRATE 2'h3
`define DSS_AB_CLEAR       2'h0
`define DSS_AB_OFFSET_NULL 2'h1

`endif

// file: hdl/dss_tick_div.v
// One-cycle count enable divider for the sequencer's timers.
// Assumes a single system clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "dss_defines.vh"

module dss_tick_div (
    CLK,
    SYS_RST,
    DIVISOR,
    TICK
);
    input  wire                  CLK;
    input  wire                  SYS_RST;
    input  wire [`DSS_DIV_W-1:0] DIVISOR;
    output reg                   TICK;

    reg [`DSS_DIV_W-1:0] count;

    always @(posedge CLK) begin
        if (SYS_RST) begin
            count <= {`DSS_DIV_W{1'b0}};
            TICK  <= 1'b0;
        end else if (count + 16'h0001 >= DIVISOR) begin
            count <= {`DSS_DIV_W{1'b0}};
            TICK  <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            TICK  <= 1'b0;
        end
    end
endmodule // dss_tick_div

// file: hdl/dss_sequencer.v
// Host-side sequencer stepping a dual-slope front end through its four phases.
// Assumes the comparator pin is asynchronous; the phase pins go straight to the device.
`timescale 1ns/1ps
`include "dss_defines.vh"

module dss_sequencer #(
    parameter [`DSS_CNT_W-1:0] TINT_CYCLES = `DSS_TINT_CYCLES
) (
    input  wire                  CLK,
    input  wire                  SYS_RST,
    input  wire                  START,
    input  wire                  ZERO_CROSS_OUT,
    output reg                   PHASE_A,
    output reg                   PHASE_B,
    output wire                  BUSY,
    output reg                   DONE,
    output reg  [`DSS_CNT_W-1:0] RESULT,
    output reg                   SIGN,
    output reg                   OVERRANGE
);

    ////////////////////////////////////////////////////////////////////////////
    localparam [5:0] ST_POWERUP   = 6'h01;
    localparam [5:0] ST_IDLE      = 6'h02;
    localparam [5:0] ST_AUTOZERO  = 6'h04;
    localparam [5:0] ST_INTEGRATE = 6'h08;
    localparam [5:0] ST_DEINT     = 6'h10;
    localparam [5:0] ST_CLEAR     = 6'h20;

    localparam [`DSS_CNT_W-1:0] ONE = 32'h00000001;

    // Phase code for a state
    function [1:0] phase_code;
        input [5:0] st;
        begin
            case (st)
                ST_INTEGRATE: phase_code = `DSS_AB_INTEGRATE;
                ST_DEINT:     phase_code = `DSS_AB_DEINTEGRATE;
                ST_CLEAR:     phase_code = `DSS_AB_CLEAR;
                default:      phase_code = `DSS_AB_OFFSET_NULL;
            endcase
        end
    endfunction

    reg  [5:0]            state;
    reg  [5:0]            next_state;
    reg  [`DSS_CNT_W-1:0] timer;
    reg                   cmp_meta;
    reg                   cmp_sync;
    reg                   cmp_prev;
    wire                  cmp_fall;
    wire                  tick;
    wire [1:0]            next_ab;
    wire                  int_end;
    wire                  deint_limit;

    ////////////////////////////////////////////////////////////////////////////
    // Comparator pin synchroniser and edge detect
    always @(posedge CLK) begin
        if (SYS_RST) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
            cmp_prev <= 1'b0;
        end else begin
            cmp_meta <= ZERO_CROSS_OUT;
            cmp_sync <= cmp_meta;
            cmp_prev <= cmp_sync;
        end
    end

    assign cmp_fall = cmp_prev & ~cmp_sync;

    // Unit tick fixed at one clock so the count resolves to the cycle
    dss_tick_div u_tick (
        .CLK     (CLK),
        .SYS_RST (SYS_RST),
        .DIVISOR (16'h0001),
        .TICK    (tick)
    );

    assign int_end     = (timer + ONE >= TINT_CYCLES);
    assign deint_limit = (timer + ONE >= {TINT_CYCLES[`DSS_CNT_W-2:0], 1'b0});

    ////////////////////////////////////////////////////////////////////////////
    // Phase sequence
    always @* begin
        next_state = state;
        case (state)
            ST_POWERUP:   if (tick && int_end) next_state = ST_IDLE;
            ST_IDLE:      if (START) next_state = ST_AUTOZERO;
            ST_AUTOZERO:  if (tick && int_end) next_state = ST_INTEGRATE;
            ST_INTEGRATE: if (tick && int_end) next_state = ST_DEINT;
            ST_DEINT: begin
                if (cmp_fall) begin
                    next_state = ST_CLEAR;
                end else if (tick && deint_limit) begin
                    next_state = ST_CLEAR;
                end
            end
            ST_CLEAR:     if (cmp_sync) next_state = ST_IDLE;
            default:      next_state = ST_POWERUP;
        endcase
    end

    assign next_ab = phase_code(next_state);
    assign BUSY    = (state != ST_IDLE) && (state != ST_POWERUP);

    ////////////////////////////////////////////////////////////////////////////
    // Pins, timer and result registers
    always @(posedge CLK) begin
        if (SYS_RST) begin
            state     <= ST_POWERUP;
            PHASE_A   <= 1'b0;
            PHASE_B   <= 1'b1;
            timer     <= {`DSS_CNT_W{1'b0}};
            DONE      <= 1'b0;
            RESULT    <= {`DSS_CNT_W{1'b0}};
            SIGN      <= 1'b0;
            OVERRANGE <= 1'b0;
        end else begin
            state   <= next_state;
            PHASE_A <= next_ab[1];
            PHASE_B <= next_ab[0];
            DONE    <= 1'b0;
            if (next_state != state) begin
                timer <= {`DSS_CNT_W{1'b0}};
            end else if (tick) begin
                timer <= timer + ONE;
            end
            // Sign taken at the last integrate cycle only, never early
            if (state == ST_INTEGRATE && next_state == ST_DEINT) begin
                SIGN <= cmp_sync;
            end
            if (state == ST_DEINT && next_state == ST_CLEAR) begin
                RESULT    <= timer + ONE;
                OVERRANGE <= ~cmp_fall;
            end
            // Clear length follows the comparator; auto-zero level is unused
            if (state == ST_CLEAR && next_state == ST_IDLE) begin
                DONE <= 1'b1;
            end
        end
    end
endmodule // dss_sequencer

// file: verif/dss_sequencer_monitor.sv
// Concurrent checks on the phase sequencer ports.
// Assumes it is bound onto dss_sequencer; one clock domain.
`timescale 1ns/1ps
module dss_sequencer_monitor #(parameter [31:0] TINT_CYCLES = 32'h14) (
    input wire        CLK,
    input wire        SYS_RST,
    input wire        START,
    input wire        ZERO_CROSS_OUT,
    input wire        PHASE_A,
    input wire        PHASE_B,
    input wire        BUSY,
    input wire        DONE,
    input wire        SIGN,
    input wire        OVERRANGE,
    input wire [31:0] RESULT
);
    wire [1:0]  ab = {PHASE_A, PHASE_B};
    reg  [1:0]  ab_q = 2'h1;
    reg  [31:0] run = 32'h0;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    always @(posedge CLK) begin
        ab_q <= ab;
        run  <= (ab != ab_q) ? 32'h0 : run + 32'h1;
    end
    chk_reset_idle: assert property (disable iff (1'b0) SYS_RST |=> ab == 2'h1 && !DONE)
        else $error("phase not auto-zero after reset");
    chk_phase_order: assert property (ab != ab_q |-> {ab_q, ab} inside {4'h6, 4'hB, 4'hC, 4'h1})
        else $error("illegal phase step");
    chk_int_length: assert property (ab_q == 2'h2 && ab == 2'h3 |-> run + 32'h2 >= TINT_CYCLES && run <= TINT_CYCLES)
        else $error("integrate length wrong");
    chk_deint_limit: assert property (ab == 2'h3 |-> run < 2 * TINT_CYCLES + 32'h2)
        else $error("deintegrate past its limit");
    // Pin still high two edges back means the host has not yet seen a fall
    chk_over_flag: assert property (ab == 2'h3 && run + 32'h2 >= 2 * TINT_CYCLES && $past(ZERO_CROSS_OUT, 2) |-> ##[0:3] OVERRANGE)
        else $error("overrange not flagged");
    chk_deint_stop: assert property (ab == 2'h3 && $fell(ZERO_CROSS_OUT) |-> ##[1:6] ab == 2'h0)
        else $error("deintegrate not ended on fall");
    chk_clear_end: assert property (ab == 2'h0 && $rose(ZERO_CROSS_OUT) |-> ##[1:6] ab == 2'h1)
        else $error("clear not ended on rise");
    chk_done_pulse: assert property (DONE |-> ab == 2'h1 && ($past(ab_q) == 2'h0 || ab_q == 2'h0) ##1 !DONE)
        else $error("done pulse misplaced");
    chk_idle_phase: assert property (!BUSY |-> ab == 2'h1)
        else $error("idle outside auto-zero");
    cov_conv: cover property (DONE && !OVERRANGE);
    cov_over: cover property (DONE && OVERRANGE);
    cov_neg: cover property (DONE && !SIGN);
endmodule // dss_sequencer_monitor
bind dss_sequencer dss_sequencer_monitor #(.TINT_CYCLES(TINT_CYCLES)) u_mon (
    .CLK            (CLK),
    .SYS_RST        (SYS_RST),
    .START          (START),
    .ZERO_CROSS_OUT (ZERO_CROSS_OUT),
    .PHASE_A        (PHASE_A),
    .PHASE_B        (PHASE_B),
    .BUSY           (BUSY),
    .DONE           (DONE),
    .SIGN           (SIGN),
    .OVERRANGE      (OVERRANGE),
    .RESULT         (RESULT)
);

// file: verif/dss_frontend_model.sv
// Behavioural comparator of the dual-slope front end.
// Assumes the phase pins come straight from the host sequencer.
`timescale 1ns/1ps
module dss_frontend_model #(parameter [31:0] LAG = 32'h4) (
    input  wire        CLK,
    input  wire        PHASE_A,
    input  wire        PHASE_B,
    input  wire        POS,
    input  wire [31:0] DLEN,
    input  wire [31:0] CLEN,
    output reg         ZERO_CROSS_OUT = 1'b0
);
    reg  [1:0]  ab_q = 2'h1;
    reg  [31:0] cnt = 32'h0;
    wire [31:0] n = ({PHASE_A, PHASE_B} != ab_q) ? 32'h0 : cnt + 32'h1;
    always @(posedge CLK) begin
        ab_q <= {PHASE_A, PHASE_B};
        cnt  <= n;
        case ({PHASE_A, PHASE_B})
            2'h1: ZERO_CROSS_OUT <= ~ZERO_CROSS_OUT;
            2'h2: ZERO_CROSS_OUT <= (n < 3) ? ~ZERO_CROSS_OUT : POS;
            2'h3: ZERO_CROSS_OUT <= (n < DLEN + LAG);
            default: ZERO_CROSS_OUT <= (n >= CLEN + LAG);
        endcase
    end
endmodule // dss_frontend_model

// file: verif/dss_sequencer_tb_top.sv
// Self-checking bench: sequencer against a behavioural front end.
// Assumes the monitor is bound; integrate length shortened to 20 cycles.
`timescale 1ns/1ps
module dss_sequencer_tb_top;
    localparam [31:0] TINT = 32'h14;
    localparam [31:0] LAG = 32'h4;
    reg clk = 1'b0, rst = 1'b1, start = 1'b0, pos = 1'b0;
    reg [31:0] dlen = 32'h5, clen = 32'h3;
    wire zc, pa, pb, busy, done, sign, ovr;
    wire [31:0] result;
    integer error_cnt = 0, n_compared = 0, seed = 59240, i, k, lead;
    always #2 clk = ~clk;
    dss_sequencer #(.TINT_CYCLES(TINT)) DUT (.CLK(clk), .SYS_RST(rst), .START(start),
        .ZERO_CROSS_OUT(zc), .PHASE_A(pa), .PHASE_B(pb), .BUSY(busy), .DONE(done),
        .RESULT(result), .SIGN(sign), .OVERRANGE(ovr));
    dss_frontend_model #(.LAG(LAG)) u_fe (.CLK(clk), .PHASE_A(pa), .PHASE_B(pb),
        .POS(pos), .DLEN(dlen), .CLEN(clen), .ZERO_CROSS_OUT(zc));
    function exp_ovr(input [31:0] d);
        // Host sees the pin fall three flops late; a fall seen at the limit still counts
        exp_ovr = d + LAG + 32'h4 > 2 * TINT;
    endfunction
    task chk(input string nm, input [31:0] lo, input [31:0] hi, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if ((got >= lo && got <= hi) !== 1'b1) begin
                error_cnt = error_cnt + 1;
                $display("mismatch %0s expected %0d seen %0d", nm, lo, got);
            end
        end
    endtask
    task stop_test;
        begin
            if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task conv(input p, input [31:0] d, input [31:0] c);
        begin
            @(negedge clk);
            pos = p;
            dlen = d;
            clen = c;
            start = 1'b1;
            for (k = 0; k < 400 && busy !== 1'b1; k = k + 1) @(negedge clk);
            lead = k;
            start = 1'b0;
            repeat (30) @(negedge clk);
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            for (k = 0; k < 400 && done !== 1'b1; k = k + 1) @(negedge clk);
            if (k == 400) begin
                error_cnt = error_cnt + 1;
                $display("mismatch done expected 1 seen 0");
                stop_test;
            end
            chk("sign", p, p, sign);
            chk("overrange", exp_ovr(d), exp_ovr(d), ovr);
            if (!exp_ovr(d)) chk("result", d + LAG, d + LAG + 32'h5, result);
            repeat (3) @(negedge clk);
            chk("busy", 0, 0, busy);
        end
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        conv(1'b1, 32'h1, 32'h1);
        conv(1'b0, 32'h18, 32'h6);
        conv(1'b1, 32'h3E8, 32'h2);
        conv(1'b0, 32'h20, 32'h5);
        conv(1'b1, 32'h21, 32'h0);
        for (i = 0; i < 6; i = i + 1)
            conv($random(seed) % 2 != 0, {$random(seed)} % 24 + 1, {$random(seed)} % 8);
        @(negedge clk);
        start = 1'b1;
        repeat (25) @(negedge clk);
        rst = 1'b1;
        start = 1'b0;
        repeat (4) @(negedge clk);
        chk("phase", 2'h1, 2'h1, {pa, pb});
        rst = 1'b0;
        conv(1'b0, 32'h7, 32'h4);
        chk("lead", TINT, 32'h3E8, lead);
        stop_test;
    end
endmodule // dss_sequencer_tb_top
